// ### logic/adrs_status.sv
// Per-sample data-ready and overwrite status byte seen at address zero while FIFO mode is off.
// Acquisition strobes come from the sample path and high-byte read strobes
// from the serial register interface, all on sys_clk_i, one cycle each.
`timescale 1ns/10ps

module adrs_status (
   input  wire logic                  sys_clk_i,
   input  wire logic                  rst_n_i,
   input  wire adrs_pkg::adrs_axis_t  acq_done_i,
   input  wire adrs_pkg::adrs_axis_t  axis_en_i,
   input  wire adrs_pkg::adrs_axis_t  high_rd_i,
   input  wire logic [1:0]            fifo_mode_i,
   input  wire logic [7:0]            fifo_status_i,
   output adrs_pkg::adrs_status_t     status_o,
   output logic [7:0]                 addr0_data_o
);

   // ********************************************************
   // Helpers
   // ********************************************************
   function automatic logic [2:0] axis_bits(input adrs_pkg::adrs_axis_t a);
      axis_bits = {a.z, a.y, a.x};
   endfunction : axis_bits

   logic [2:0] acq;
   logic [2:0] rd;
   logic [2:0] en;
   logic [2:0] dr_q;
   logic [2:0] ow_q;
   logic [2:0] ow_set;
   logic       zyx_ready_q;
   logic       zyx_overwrite_q;
   logic       set_ready_any;
   logic       set_overwrite_any;
   logic [2:0] read_seen;
   logic [2:0] next_read_seen;
   logic       all_read;
   adrs_pkg::adrs_status_t next_status;

   assign acq = axis_bits(acq_done_i);
   assign rd  = axis_bits(high_rd_i);
   assign en  = axis_bits(axis_en_i);

   // ********************************************************
   // Per-axis ready and overwrite flags
   // ********************************************************
   // Overwrite means the ready bit was still up when the next sample came
   assign ow_set = acq & dr_q;

   for (genvar i = 0; i < 3; i++) begin : g_axis
      adrs_flag_cell u_ready (
         .sys_clk_i (sys_clk_i),
         .rst_n_i   (rst_n_i),
         .set_i     (acq[i]),
         .clr_i     (rd[i]),
         .flag_o    (dr_q[i])
      );
      adrs_flag_cell u_overwrite (
         .sys_clk_i (sys_clk_i),
         .rst_n_i   (rst_n_i),
         .set_i     (ow_set[i]),
         .clr_i     (rd[i]),
         .flag_o    (ow_q[i])
      );
   end

   // ********************************************************
   // Combined flags and tracking of the three high-byte reads
   // ********************************************************
   // Disabled axes never raise the combined ready bit
   assign set_ready_any     = |(acq & en);
   assign set_overwrite_any = |ow_set;
   assign all_read          = &(read_seen | rd);

   // A new sample of an enabled axis restarts the tally: the host must fetch the fresh set
   always_comb begin
      if (set_ready_any || all_read) begin
         next_read_seen = adrs_pkg::AXIS_NONE;
      end else begin
         next_read_seen = read_seen | rd;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         read_seen <= adrs_pkg::AXIS_NONE;
      end else begin
         read_seen <= next_read_seen;
      end
   end

   adrs_flag_cell u_zyx_ready (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n_i),
      .set_i     (set_ready_any),
      .clr_i     (all_read),
      .flag_o    (zyx_ready_q)
   );

   adrs_flag_cell u_zyx_overwrite (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n_i),
      .set_i     (set_overwrite_any),
      .clr_i     (all_read),
      .flag_o    (zyx_overwrite_q)
   );

   assign status_o = {zyx_overwrite_q, ow_q, zyx_ready_q, dr_q};

   // ********************************************************
   // Address zero view
   // ********************************************************
   // Built from next flag values so the view never lags the flags
   assign next_status = {(zyx_overwrite_q & ~all_read) | set_overwrite_any,
                         (ow_q & ~rd) | ow_set,
                         (zyx_ready_q & ~all_read) | set_ready_any,
                         (dr_q & ~rd) | acq};

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         addr0_data_o <= adrs_pkg::STATUS_RST;
      end else if (fifo_mode_i == adrs_pkg::FIFO_MODE_OFF) begin
         addr0_data_o <= next_status;
      end else begin
         addr0_data_o <= fifo_status_i;
      end
   end

   // ********************************************************
   // Assertions
   // ********************************************************
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence x_read_no_acq_s;
      high_rd_i.x && !acq_done_i.x;
   endsequence

   sequence x_unread_acq_s;
      status_o.x_ready && acq_done_i.x;
   endsequence

   sequence all_three_read_s;
      (high_rd_i.x && high_rd_i.y && high_rd_i.z && !(|acq_done_i));
   endsequence

   view_ready_a: assert property (
      fifo_mode_i == adrs_pkg::FIFO_MODE_OFF |=> addr0_data_o == status_o)
      else $error("address zero does not show the ready status");

   view_fifo_a: assert property (
      fifo_mode_i != adrs_pkg::FIFO_MODE_OFF |=> addr0_data_o == $past(fifo_status_i))
      else $error("address zero does not show the fifo status");

   x_ready_set_a: assert property (
      acq_done_i.x |=> status_o.x_ready)
      else $error("x ready not set by new sample");

   x_ready_clr_a: assert property (
      x_read_no_acq_s |=> !status_o.x_ready && !status_o.x_overwrite)
      else $error("x flags not cleared by high byte read");

   yz_ready_a: assert property (
      (acq_done_i.y |=> status_o.y_ready) and (acq_done_i.z |=> status_o.z_ready))
      else $error("y or z ready not set by new sample");

   x_overwrite_a: assert property (
      x_unread_acq_s |=> status_o.x_overwrite && status_o.zyx_overwrite)
      else $error("x overwrite not flagged");

   yz_overwrite_a: assert property (
      ((status_o.y_ready && acq_done_i.y) |=> status_o.y_overwrite) and
      ((status_o.z_ready && acq_done_i.z) |=> status_o.z_overwrite))
      else $error("y or z overwrite not flagged");

   combo_ready_a: assert property (
      (|(axis_bits(acq_done_i) & axis_bits(axis_en_i))) |=> status_o.zyx_ready)
      else $error("combined ready not set");

   combo_clear_a: assert property (
      all_three_read_s |=> status_o.zyx_ready == 1'b0 && status_o.zyx_overwrite == 1'b0)
      else $error("combined flags not cleared after all high reads");

   read_collide_a: assert property (
      acq_done_i.x && high_rd_i.x |=>
      status_o.x_ready && (status_o.zyx_ready || !$past(axis_en_i.x)))
      else $error("sample lost on colliding read");

   read_only_a: assert property (
      !(|acq_done_i) && !(|high_rd_i) |=> $stable(status_o))
      else $error("status changed without cause");

   yz_clear_a: assert property (
      ((high_rd_i.y && !acq_done_i.y) |=> !status_o.y_ready && !status_o.y_overwrite) and
      ((high_rd_i.z && !acq_done_i.z) |=> !status_o.z_ready && !status_o.z_overwrite))
      else $error("y or z flags not cleared by high byte read");

   // Combined ready may only rise on a sample of an enabled axis
   combo_rise_a: assert property (
      !(|(axis_bits(acq_done_i) & axis_bits(axis_en_i))) && !status_o.zyx_ready
      |=> !status_o.zyx_ready)
      else $error("combined ready rose without enabled sample");

   sequence no_overwrite_s;
      !status_o.zyx_overwrite &&
      !(|(axis_bits(acq_done_i) & {status_o.z_ready, status_o.y_ready, status_o.x_ready}));
   endsequence

   combo_ow_rise_a: assert property (
      no_overwrite_s |=> !status_o.zyx_overwrite)
      else $error("combined overwrite rose without overwrite");

   view_clear_a: assert property (
      all_three_read_s && fifo_mode_i == adrs_pkg::FIFO_MODE_OFF
      |=> addr0_data_o[7] == 1'b0 && addr0_data_o[3] == 1'b0)
      else $error("address zero view keeps combined flags after reads");

endmodule : adrs_status

// ### shared/adrs_pkg.sv
// Package of the accelerometer data-ready status block.
// Shared by the status block and its flag cell; no other dependency.
package adrs_pkg;

   // ********************************************************
   // Register map
   // ********************************************************
   localparam logic [7:0] STATUS_ADDR      = 8'h00;
   localparam logic [7:0] STATUS_RST       = 8'h00;
   localparam int         FIFO_MODE_W      = 2;
   localparam logic [1:0] FIFO_MODE_OFF    = 2'h0;
   localparam logic       FLAG_RST         = 1'h0;
   localparam logic [2:0] AXIS_NONE        = 3'h0;
   localparam logic [2:0] AXIS_ALL         = 3'h7;

   // ********************************************************
   // Field layout of the status byte, bit 7 first
   // ********************************************************
   typedef struct packed {
      logic zyx_overwrite;
      logic z_overwrite;
      logic y_overwrite;
      logic x_overwrite;
      logic zyx_ready;
      logic z_ready;
      logic y_ready;
      logic x_ready;
   } adrs_status_t;

   // One strobe per axis, Z in bit 2 down to X in bit 0
   typedef struct packed {
      logic z;
      logic y;
      logic x;
   } adrs_axis_t;

endpackage : adrs_pkg

// ### logic/adrs_flag_cell.sv
// Sticky status bit with a set input and a clear input.
// Set and clear come from logic on the same clock as the cell.
`timescale 1ns/10ps

module adrs_flag_cell (
   input  wire logic sys_clk_i,
   input  wire logic rst_n_i,
   input  wire logic set_i,
   input  wire logic clr_i,
   output logic      flag_o
);

   // ********************************************************
   // Flag storage
   // ********************************************************
   // Set beats clear so a sample landing on the read is not lost
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flag_o <= adrs_pkg::FLAG_RST;
      end else if (set_i) begin
         flag_o <= 1'b1;
      end else if (clr_i) begin
         flag_o <= 1'b0;
      end
   end

endmodule : adrs_flag_cell

// ### testbench/adrs_host_model.sv
// Host side model: one-cycle reads of the axis output high bytes.
// Assumes a clock shared with the bench and inputs moved 1 ns after the edge.
`timescale 1ns/10ps

module adrs_host_model (
   input  wire logic            sys_clk_i,
   output adrs_pkg::adrs_axis_t high_rd_o
);
   initial high_rd_o = adrs_pkg::AXIS_NONE;

   // Held for exactly one edge so one read never counts twice
   task automatic read_high(input adrs_pkg::adrs_axis_t axes);
      @(posedge sys_clk_i) #1;
      high_rd_o = axes;
      @(posedge sys_clk_i) #1;
      high_rd_o = adrs_pkg::AXIS_NONE;
   endtask : read_high
endmodule : adrs_host_model

// ### testbench/accel_data_ready_status_bench.sv
// Self-checking bench of the data-ready status byte.
// Assumes adrs_pkg is compiled first and the host model drives the reads.
`timescale 1ns/10ps

module accel_data_ready_status_bench;
   logic                   sys_clk_i     = 1'b0;
   logic                   rst_n_i       = 1'b0;
   adrs_pkg::adrs_axis_t   acq_done_i    = adrs_pkg::AXIS_NONE;
   adrs_pkg::adrs_axis_t   axis_en_i     = adrs_pkg::AXIS_ALL;
   adrs_pkg::adrs_axis_t   high_rd_i;
   logic [1:0]             fifo_mode_i   = adrs_pkg::FIFO_MODE_OFF;
   logic [7:0]             fifo_status_i = 8'h00;
   adrs_pkg::adrs_status_t status_o;
   logic [7:0]             addr0_data_o;
   int                     err_total     = 0;
   int                     n_checks      = 0;

   always #50 sys_clk_i = ~sys_clk_i;

   adrs_status u_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .acq_done_i(acq_done_i),
      .axis_en_i(axis_en_i), .high_rd_i(high_rd_i), .fifo_mode_i(fifo_mode_i),
      .fifo_status_i(fifo_status_i), .status_o(status_o), .addr0_data_o(addr0_data_o));
   adrs_host_model u_host (.sys_clk_i(sys_clk_i), .high_rd_o(high_rd_i));

   // ********************************************************
   // Shared tasks
   // ********************************************************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Sample strobes and host reads land on the same edge; status read after it
   task automatic step(input logic [2:0] acq, input logic [2:0] rd, input logic [7:0] exp);
      fork
         begin
            @(posedge sys_clk_i) #1;
            acq_done_i = acq;
            @(posedge sys_clk_i) #1;
            acq_done_i = adrs_pkg::AXIS_NONE;
         end
         u_host.read_high(rd);
      join
      check(status_o, exp);
   endtask : step

   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : report_and_stop

   // ********************************************************
   // Tests
   // ********************************************************
   initial begin
      #100000;
      err_total++;
      report_and_stop();
   end

   initial begin
      repeat (5) @(posedge sys_clk_i);
      #1;
      check(status_o, adrs_pkg::STATUS_RST);
      check(addr0_data_o, 8'h00);
      rst_n_i = 1'b1;
      step(3'h1, 3'h0, 8'h09);
      step(3'h1, 3'h0, 8'h99);
      step(3'h6, 3'h0, 8'h9F);
      step(3'h6, 3'h0, 8'hFF);
      step(3'h0, 3'h0, 8'hFF);
      check(addr0_data_o, 8'hFF);
      step(3'h0, 3'h1, 8'hEE);
      step(3'h0, 3'h2, 8'hCC);
      step(3'h0, 3'h4, 8'h00);
      check(addr0_data_o, 8'h00);
      step(3'h1, 3'h1, 8'h09);
      step(3'h0, 3'h3, 8'h08);
      // A fresh sample restarts the three-read tally
      step(3'h2, 3'h0, 8'h0A);
      step(3'h0, 3'h4, 8'h0A);
      step(3'h0, 3'h3, 8'h00);
      check(addr0_data_o, 8'h00);
      axis_en_i = 3'h6;
      step(3'h1, 3'h0, 8'h01);
      step(3'h0, 3'h1, 8'h00);
      axis_en_i = adrs_pkg::AXIS_ALL;
      for (int m = 1; m < 4; m++) begin
         fifo_mode_i = 2'(m);
         fifo_status_i = 8'hA0 + 8'(m);
         repeat (2) @(posedge sys_clk_i);
         #1;
         check(addr0_data_o, 8'hA0 + 8'(m));
      end
      fifo_mode_i = adrs_pkg::FIFO_MODE_OFF;
      step(3'h4, 3'h0, 8'h0C);
      step(3'h0, 3'h0, 8'h0C);
      check(addr0_data_o, 8'h0C);
      // Reset in mid-run drops set flags at once
      rst_n_i = 1'b0;
      #1;
      check(status_o, 8'h00);
      @(posedge sys_clk_i) #1;
      rst_n_i = 1'b1;
      step(3'h0, 3'h0, 8'h00);
      report_and_stop();
   end
endmodule : accel_data_ready_status_bench
